// ==== fbmc_cfg.svh ====
// constants for the fieldbus slave mode configuration register bank
`ifndef FBMC_CFG_SVH
`define FBMC_CFG_SVH

// register indices and byte addresses (index times four)
`define FBMC_IDX_MODE_LO     6'h06
`define FBMC_IDX_MODE_HI     6'h07
`define FBMC_IDX_CTRL        6'h08
`define FBMC_ADDR_W          8
`define FBMC_ADDR_OF(idx)    ({(idx), 2'b00})

// low byte field positions
`define FBMC_LO_START_OFF    0
`define FBMC_LO_STOP_OFF     1
`define FBMC_LO_MIN_TSD_LSB  2
`define FBMC_LO_MIN_TSD_MSB  3
`define FBMC_LO_IRQ_POL      4
`define FBMC_LO_EARLY_RDY    5
`define FBMC_LO_SYNC_SUP     6
`define FBMC_LO_FREEZE_SUP   7

// high byte field positions (register bits 13..8)
`define FBMC_HI_SLAVE_MODE   0
`define FBMC_HI_EOI_TB       1
`define FBMC_HI_USER_TB      2
`define FBMC_HI_WATCHDOG_TEST_MODE      3
`define FBMC_HI_DED_PRM      4
`define FBMC_HI_FAILSAFE     5
`define FBMC_HI_MASK         8'h3F

// control register fields
`define FBMC_CTRL_GO         0
`define FBMC_CTRL_ONLINE     1

// reset values
`define FBMC_RST_MODE_LO     8'h00
`define FBMC_RST_MODE_HI     6'h00

`endif

// ==== fbmc_pkg.sv ====
// types for the fieldbus slave mode configuration register bank
`default_nettype none
package fbmc_pkg;

  typedef struct packed {
    logic       freeze_support_flag;
    logic       sync_support_flag;
    logic       early_ready;
    logic       irq_polarity;
    logic [1:0] min_station_delay;
    logic       stop_bit_check_off;
    logic       start_bit_check_off;
  } fbmc_mode_lo_t;

  typedef struct packed {
    logic failsafe_zero_data_accept;
    logic dedicated_param_buffer_mode;
    logic watchdog_test_mode;
    logic user_timebase_select;
    logic eoi_timebase_select;
    logic slave_mode_enable;
  } fbmc_mode_hi_t;

  typedef struct packed {
    logic       valid;
    logic       start_bit_check_off;
    logic       stop_bit_check_off;
  } fbmc_set_param_t;

  typedef struct packed {
    logic valid;
    logic len_zero;
    logic in_data_exchange;
  } fbmc_dx_frame_t;

  typedef enum logic [1:0] {
    FBMC_OFFLINE = 2'b01,
    FBMC_ONLINE  = 2'b10
  } fbmc_state_t;

endpackage
`default_nettype wire

// ==== fbmc_dx_filter.sv ====
// accept or reject decision for received data-exchange telegrams
`default_nettype none
module fbmc_dx_filter
  import fbmc_pkg::*;
(
  // clock and reset
  input  wire logic     core_clk_in,
  input  wire logic     rst_b_in,
  // telegram and mode
  input  wire fbmc_dx_frame_t frame_in,
  input  wire logic     failsafe_in,
  // decision pulses
  output logic          accept_out,
  output logic          reject_out
);

  logic zero_ok;

  // zero length only passes in data exchange with fail-safe on
  assign zero_ok = failsafe_in & frame_in.in_data_exchange;

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      accept_out <= 1'b0;
      reject_out <= 1'b0;
    end else begin
      accept_out <= frame_in.valid & (~frame_in.len_zero | zero_ok);
      reject_out <= frame_in.valid & frame_in.len_zero & ~zero_ok;
    end
  end

endmodule
`default_nettype wire

// ==== fbmc_mode_regs.sv ====
// mode configuration register bank with apb slave and offline control
`include "fbmc_cfg.svh"
`default_nettype none
module fbmc_mode_regs
  import fbmc_pkg::*;
(
  // clock and reset
  input  wire logic                     core_clk_in,
  input  wire logic                     rst_b_in,
  // apb slave
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [`FBMC_ADDR_W-1:0]  paddr_in,
  input  wire logic [31:0]              pwdata_in,
  output logic [31:0]                   prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  // protocol events from the telegram engine
  input  wire fbmc_set_param_t          set_param_in,
  input  wire fbmc_dx_frame_t           dx_frame_in,
  // serial receiver controls
  output logic                          start_check_en_out,
  output logic                          stop_check_en_out,
  // mode outputs
  output fbmc_mode_lo_t                 mode_lo_out,
  output fbmc_mode_hi_t                 mode_hi_out,
  output logic                          param_dedicated_buf_out,
  output logic                          controller_online_out,
  // data telegram decision
  output logic                          dx_accept_out,
  output logic                          dx_reject_out
);

  fbmc_mode_lo_t             mode_lo_q;
  fbmc_mode_hi_t             mode_hi_q;
  fbmc_state_t               state_q;
  logic                      pready_q;
  logic                      pslverr_q;
  logic [31:0]               prdata_q;
  logic                      start_en_q;
  logic                      stop_en_q;
  logic                      setup;
  logic                      wr_done;
  logic                      online;
  logic                      sp_hit;
  logic                      wr_lo;
  logic                      wr_hi;
  logic                      wr_ctrl;
  logic [`FBMC_ADDR_W-1:0]   a_lo;
  logic [`FBMC_ADDR_W-1:0]   a_hi;
  logic [`FBMC_ADDR_W-1:0]   a_ctrl;

  function automatic logic hit(input logic [`FBMC_ADDR_W-1:0] a,
                               input logic [`FBMC_ADDR_W-1:0] b);
    hit = (a == b);
  endfunction

  // host write landing in a mode byte, refused while online
  function automatic logic mode_wr(input logic                    done,
                                   input logic                    on,
                                   input logic [`FBMC_ADDR_W-1:0] a,
                                   input logic [`FBMC_ADDR_W-1:0] b);
    mode_wr = done & ~on & hit(a, b);
  endfunction

  // receiver enable from a check-off bit: 0 monitors, 1 skips
  function automatic logic check_en(input logic off);
    check_en = ~off;
  endfunction

  // read word of an address, holes read zero
  function automatic logic [31:0] rd_word(input logic [`FBMC_ADDR_W-1:0] a,
                                          input fbmc_mode_lo_t           lo,
                                          input fbmc_mode_hi_t           hi,
                                          input logic                    on);
    rd_word = 32'h0000_0000;
    if (hit(a, `FBMC_ADDR_OF(`FBMC_IDX_MODE_LO))) begin
      rd_word = {{24{1'b0}}, lo};
    end else if (hit(a, `FBMC_ADDR_OF(`FBMC_IDX_MODE_HI))) begin
      rd_word = {{26{1'b0}}, hi};
    end else if (hit(a, `FBMC_ADDR_OF(`FBMC_IDX_CTRL))) begin
      rd_word = {{30{1'b0}}, on, on};
    end
  endfunction

  // error answer: holes always, mode bytes when written online
  function automatic logic bus_err(input logic [`FBMC_ADDR_W-1:0] a,
                                   input logic                    w,
                                   input logic                    on);
    bus_err = 1'b1;
    if (hit(a, `FBMC_ADDR_OF(`FBMC_IDX_MODE_LO))) begin
      bus_err = w & on;
    end else if (hit(a, `FBMC_ADDR_OF(`FBMC_IDX_MODE_HI))) begin
      bus_err = w & on;
    end else if (hit(a, `FBMC_ADDR_OF(`FBMC_IDX_CTRL))) begin
      bus_err = 1'b0;
    end
  endfunction

  assign a_lo    = `FBMC_ADDR_OF(`FBMC_IDX_MODE_LO);
  assign a_hi    = `FBMC_ADDR_OF(`FBMC_IDX_MODE_HI);
  assign a_ctrl  = `FBMC_ADDR_OF(`FBMC_IDX_CTRL);
  assign setup   = psel_in & ~penable_in;
  assign wr_done = psel_in & penable_in & pready_q & pwrite_in;
  assign online  = (state_q == FBMC_ONLINE);
  assign wr_lo   = mode_wr(wr_done, online, paddr_in, a_lo);
  assign wr_hi   = mode_wr(wr_done, online, paddr_in, a_hi);
  assign wr_ctrl = wr_done & hit(paddr_in, a_ctrl);
  // set-param only rewrites the check bits in slave mode
  assign sp_hit  = set_param_in.valid & mode_hi_q.slave_mode_enable;

  // ready answers in the cycle after setup, no wait states
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  // error flag rides with ready
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= bus_err(paddr_in, pwrite_in, online);
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  // read snapshot taken at the setup edge
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= rd_word(paddr_in, mode_lo_q, mode_hi_q, online);
    end else begin
      prdata_q <= 32'h0000_0000;
    end
  end

  // low byte; set-param wins over a host write in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      mode_lo_q <= `FBMC_RST_MODE_LO;
    end else begin
      if (wr_lo) begin
        mode_lo_q <= pwdata_in[7:0];
      end
      if (sp_hit) begin
        mode_lo_q.start_bit_check_off <= set_param_in.start_bit_check_off;
        mode_lo_q.stop_bit_check_off  <= set_param_in.stop_bit_check_off;
      end
    end
  end

  // high byte, bits 15..14 read zero
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      mode_hi_q <= `FBMC_RST_MODE_HI;
    end else if (wr_hi) begin
      mode_hi_q <= pwdata_in[5:0];
    end
  end

  // offline until go is written
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      state_q <= FBMC_OFFLINE;
    end else if (wr_ctrl) begin
      unique case (state_q)
        FBMC_OFFLINE: begin
          if (pwdata_in[`FBMC_CTRL_GO]) state_q <= FBMC_ONLINE;
        end
        FBMC_ONLINE: begin
          if (!pwdata_in[`FBMC_CTRL_GO]) state_q <= FBMC_OFFLINE;
        end
        default: state_q <= FBMC_OFFLINE;
      endcase
    end
  end

  // start-bit monitor enable, set-param value taken at once
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      start_en_q <= 1'b1;
    end else if (sp_hit) begin
      start_en_q <= check_en(set_param_in.start_bit_check_off);
    end else if (wr_lo) begin
      start_en_q <= check_en(pwdata_in[`FBMC_LO_START_OFF]);
    end
  end

  // stop-bit monitor enable, same priority as the start bit
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      stop_en_q <= 1'b1;
    end else if (sp_hit) begin
      stop_en_q <= check_en(set_param_in.stop_bit_check_off);
    end else if (wr_lo) begin
      stop_en_q <= check_en(pwdata_in[`FBMC_LO_STOP_OFF]);
    end
  end

  fbmc_dx_filter u_dx_filter (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .frame_in    (dx_frame_in),
    .failsafe_in (mode_hi_q.failsafe_zero_data_accept),
    .accept_out  (dx_accept_out),
    .reject_out  (dx_reject_out)
  );

  assign prdata_out              = prdata_q;
  assign pready_out              = pready_q;
  assign pslverr_out             = pslverr_q;
  assign start_check_en_out      = start_en_q;
  assign stop_check_en_out       = stop_en_q;
  assign mode_lo_out             = mode_lo_q;
  assign mode_hi_out             = mode_hi_q;
  assign param_dedicated_buf_out = mode_hi_q.dedicated_param_buffer_mode;
  assign controller_online_out   = state_q[1];

endmodule
`default_nettype wire

// ==== fbmc_mode_regs_monitor.sv ====
// assertion checker for the mode register bank
`include "fbmc_cfg.svh"
`default_nettype none
module fbmc_mode_regs_monitor
  import fbmc_pkg::*;
(
  // watched ports
  input wire logic                    core_clk_in,
  input wire logic                    rst_b_in,
  input wire logic                    psel_in,
  input wire logic                    penable_in,
  input wire logic                    pwrite_in,
  input wire logic [`FBMC_ADDR_W-1:0] paddr_in,
  input wire logic                    pready_out,
  input wire logic                    pslverr_out,
  input wire fbmc_set_param_t         set_param_in,
  input wire fbmc_dx_frame_t          dx_frame_in,
  input wire logic                    start_check_en_out,
  input wire logic                    stop_check_en_out,
  input wire fbmc_mode_lo_t           mode_lo_out,
  input wire fbmc_mode_hi_t           mode_hi_out,
  input wire logic                    param_dedicated_buf_out,
  input wire logic                    controller_online_out,
  input wire logic                    dx_accept_out,
  input wire logic                    dx_reject_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_rdy;
    psel_in && !penable_in |=> pready_out ##1 !pready_out;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready not a single pulse");
  property p_lock;
    psel_in && !penable_in && pwrite_in && controller_online_out
      && paddr_in inside {8'h18, 8'h1C} |=> pslverr_out;
  endproperty
  a_lock: assert property (p_lock) else $error("online mode write accepted");
  property p_sbit;
    start_check_en_out != mode_lo_out.start_bit_check_off;
  endproperty
  a_sbit: assert property (p_sbit) else $error("start check mismatch");
  property p_pbit;
    stop_check_en_out != mode_lo_out.stop_bit_check_off;
  endproperty
  a_pbit: assert property (p_pbit) else $error("stop check mismatch");
  property p_prm;
    set_param_in.valid && mode_hi_out.slave_mode_enable |=>
      mode_lo_out.start_bit_check_off == $past(set_param_in.start_bit_check_off);
  endproperty
  a_prm: assert property (p_prm) else $error("set param not applied");
  property p_fsa;
    dx_frame_in.valid && dx_frame_in.len_zero && dx_frame_in.in_data_exchange
      && mode_hi_out.failsafe_zero_data_accept |-> ##[1:2] dx_accept_out;
  endproperty
  a_fsa: assert property (p_fsa) else $error("zero frame not accepted");
  property p_fsr;
    dx_frame_in.valid && dx_frame_in.len_zero && !mode_hi_out.failsafe_zero_data_accept
      |-> ##[1:2] dx_reject_out;
  endproperty
  a_fsr: assert property (p_fsr) else $error("zero frame not rejected");
  property p_excl;
    !(dx_accept_out && dx_reject_out);
  endproperty
  a_excl: assert property (p_excl) else $error("accept and reject together");
  property p_ded;
    param_dedicated_buf_out == mode_hi_out.dedicated_param_buffer_mode;
  endproperty
  a_ded: assert property (p_ded) else $error("dedicated buffer mismatch");
  cover property (set_param_in.valid && mode_hi_out.slave_mode_enable);
  cover property (dx_accept_out);
  cover property (pslverr_out && controller_online_out);
endmodule
bind fbmc_mode_regs fbmc_mode_regs_monitor i_mon (.*);
`default_nettype wire

// ==== fbmc_host_model.sv ====
// apb host model that loads the mode configuration
`default_nettype none
module fbmc_host_model (
  // bus answer
  input  wire logic        clk_in,
  input  wire logic [31:0] prdata_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  // bus request
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic [7:0]       paddr_out,
  output logic [31:0]      pwdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;
  // one transfer, called right after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e, output bit to);
    int n;
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_in !== 1'b1 && n < 20);
    to = (n >= 20);
    r = prdata_in;
    e = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~a;
    pwdata_out <= ~d;
    @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the mode register bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fbmc_pkg::*;
  logic clk, rst_b, psel, pen, pwr, rdy, err, sc, pc, ded, onl, acc, rej;
  logic [7:0] addr;
  logic [31:0] wd, rd, rv, v, na, nr;
  fbmc_set_param_t sp;
  fbmc_dx_frame_t dx;
  fbmc_mode_lo_t lo;
  fbmc_mode_hi_t hi;
  logic [31:0] seed = 32'h315BD7C9;
  int miscompares = 0, checks_done = 0, m_lo = 0, m_hi = 0, m_on = 0;
  fbmc_mode_regs i_dut (.core_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wd), .prdata_out(rd), .pready_out(rdy),
    .pslverr_out(err), .set_param_in(sp), .dx_frame_in(dx), .start_check_en_out(sc),
    .stop_check_en_out(pc), .mode_lo_out(lo), .mode_hi_out(hi), .param_dedicated_buf_out(ded),
    .controller_online_out(onl), .dx_accept_out(acc), .dx_reject_out(rej));
  fbmc_host_model i_host (.clk_in(clk), .prdata_in(rd), .pready_in(rdy), .pslverr_in(err),
    .psel_out(psel), .penable_out(pen), .pwrite_out(pwr), .paddr_out(addr), .pwdata_out(wd));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic results();
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic xe);
    logic e;
    bit to;
    i_host.xfer(w, a, d, rv, e, to);
    chk(e, xe);
    if (to) begin
      miscompares++;
      results();
    end
  endtask
  task automatic state();
    bus(1'b0, 8'h18, 0, 1'b0);
    chk(rv, m_lo);
    bus(1'b0, 8'h1C, 0, 1'b0);
    chk(rv, m_hi);
    chk({lo, hi}, {m_lo[7:0], m_hi[5:0]});
    chk({sc, pc}, {!m_lo[0], !m_lo[1]});
    chk(ded, m_hi[4]);
    chk(onl, m_on[0]);
  endtask
  initial begin
    rst_b = 1'b0;
    sp = '0;
    dx = '0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    state();
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      bus(1'b1, 8'h18, v, 1'b0);
      bus(1'b1, 8'h1C, v >> 8, 1'b0);
      m_lo = v[7:0];
      m_hi = v[13:8];
      state();
    end
    bus(1'b1, 8'h24, 32'hFFFFFFFF, 1'b1);
    bus(1'b0, 8'h24, 0, 1'b1);
    chk(rv, 0);
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      m_hi = i % 2;
      bus(1'b1, 8'h1C, m_hi, 1'b0);
      sp <= {1'b1, v[1:0]};
      @(posedge clk);
      sp <= '0;
      @(posedge clk);
      if (m_hi[0]) m_lo[1:0] = {v[0], v[1]};
      state();
    end
    for (int i = 0; i < 8; i++) begin
      m_hi = i[2] ? 32 : 0;
      bus(1'b1, 8'h1C, m_hi, 1'b0);
      dx <= {1'b1, i[0], i[1]};
      @(posedge clk);
      dx <= '0;
      na = 0;
      nr = 0;
      repeat (4) begin
        @(posedge clk);
        na += acc;
        nr += rej;
      end
      chk(na, 32'(!i[0] || i[1] && i[2]));
      chk(nr, 32'(i[0] && !(i[1] && i[2])));
    end
    bus(1'b1, 8'h20, 1, 1'b0);
    m_on = 1;
    bus(1'b0, 8'h20, 0, 1'b0);
    chk(rv, 3);
    bus(1'b1, 8'h18, ~m_lo, 1'b1);
    state();
    bus(1'b1, 8'h20, 0, 1'b0);
    m_on = 0;
    state();
    results();
  end
endmodule
`default_nettype wire
